// file: pkg/oobseq_pkg.sv
// Constants, types and helpers shared by the out-of-band signal sequencer
// ====================================================================
package oobseq_pkg;

    // ================================================================
    // Time base
    localparam longint unsigned OOB_TIME_UNIT_FS = 666_600;
    localparam longint unsigned CLK_PERIOD_FS = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS = 100;

    // Round a span of units up to whole cycles, never below one
    function automatic int unsigned oobseqCycles(longint unsigned units);
        longint unsigned c;
        c = (units * OOB_TIME_UNIT_FS + CLK_PERIOD_FS - 1) / CLK_PERIOD_FS;
        return (c == 0) ? 1 : int'(c);
    endfunction

    // ================================================================
    // Transmit spans in units and cycles
    localparam longint unsigned BURST_UNITS = 160;
    localparam longint unsigned WAKE_IDLE_UNITS = 160;
    localparam longint unsigned INIT_IDLE_UNITS = 480;
    localparam longint unsigned SAS_IDLE_UNITS = 1440;
    localparam longint unsigned WAKE_NEG_UNITS = 280;
    localparam longint unsigned INIT_NEG_UNITS = 800;
    localparam longint unsigned SAS_NEG_UNITS = 2400;
    localparam longint unsigned PORT_SELECT_SHORT_GAP_UNITS = 3_000_000;
    localparam longint unsigned PORT_SELECT_LONG_GAP_UNITS = 12_000_000;
    localparam int unsigned BURST_CYC = oobseqCycles(BURST_UNITS);
    localparam int unsigned WAKE_IDLE_CYC = oobseqCycles(WAKE_IDLE_UNITS);
    localparam int unsigned INIT_IDLE_CYC = oobseqCycles(INIT_IDLE_UNITS);
    localparam int unsigned SAS_IDLE_CYC = oobseqCycles(SAS_IDLE_UNITS);
    localparam int unsigned WAKE_NEG_CYC = oobseqCycles(WAKE_NEG_UNITS);
    localparam int unsigned INIT_NEG_CYC = oobseqCycles(INIT_NEG_UNITS);
    localparam int unsigned SAS_NEG_CYC = oobseqCycles(SAS_NEG_UNITS);
    localparam int unsigned PORT_SELECT_SHORT_GAP_CYC = oobseqCycles(PORT_SELECT_SHORT_GAP_UNITS);
    localparam int unsigned PORT_SELECT_LONG_GAP_CYC = oobseqCycles(PORT_SELECT_LONG_GAP_UNITS);
    localparam logic [2:0] PAIRS_PER_SIGNAL = 3'h6;
    localparam logic [2:0] PORT_SELECT_SIGNALS = 3'h5;

    // Optical idle make-up
    localparam logic [2:0] OPT_IDLE_PRIMS = 3'h6;
    localparam logic [9:0] WAKE_ZERO_DWORDS = 10'h002;
    localparam logic [9:0] INIT_ZERO_DWORDS = 10'h012;
    localparam logic [9:0] SAS_ZERO_DWORDS = 10'h042;

    // ================================================================
    // Receive thresholds in ns, the COMSAS timeout in ps
    localparam int unsigned WAKE_GAP_MIN_NS = 35;
    localparam int unsigned WAKE_GAP_MAX_NS = 175;
    localparam int unsigned INIT_GAP_MAX_NS = 525;
    localparam int unsigned SAS_GAP_MAX_NS = 1575;
    localparam int unsigned SAS_TIMEOUT_PS = 13_686_000;
    localparam int unsigned SAS_TIMEOUT_CYC =
        (SAS_TIMEOUT_PS + CLK_PERIOD_NS * 1000 - 1) / (CLK_PERIOD_NS * 1000);
    localparam logic [1:0] GAPS_TO_MATCH = 2'h3;
    localparam logic [4:0] IDLE_CNT_MAX = 5'h1f;

    // ================================================================
    // Types
    typedef enum logic [1:0] {SIG_NONE, SIG_WAKE, SIG_INIT, SIG_SAS} oobseqSig_t;
    typedef enum {TX_READY, TX_IDLE, TX_BURST, TX_NEGATE} oobseqTxState_t;

    // Line control towards the serializer
    typedef struct packed {
        logic elecIdle;      // D.C. electrical idle
        logic opticalIdle;   // Idle primitives plus zero dwords
        logic [2:0] idlePrims;
        logic [9:0] zeroDwords;
        logic burstDc;       // 0011b pattern / square wave at 1.5G
        logic burstAlign3;   // ALIGN (3) at 3G
    } oobseqTxLine_t;

    // Receive events, one-cycle pulses
    typedef struct packed {
        logic wake;
        logic init;
        logic sas;
        logic sasTimeout;
    } oobseqRxEvt_t;

    // Classify a measured idle gap
    function automatic oobseqSig_t oobseqGapClass(logic [4:0] cnt);
        int unsigned ns;
        ns = int'(cnt) * CLK_PERIOD_NS;
        if (ns >= WAKE_GAP_MIN_NS && ns < WAKE_GAP_MAX_NS) return SIG_WAKE;
        if (ns >= WAKE_GAP_MAX_NS && ns < INIT_GAP_MAX_NS) return SIG_INIT;
        if (ns >= INIT_GAP_MAX_NS && ns < SAS_GAP_MAX_NS) return SIG_SAS;
        return SIG_NONE;
    endfunction

    // Gap beyond which a signal of this kind is over
    function automatic int unsigned oobseqNegNs(oobseqSig_t s);
        case (s)
            SIG_WAKE: return WAKE_GAP_MAX_NS;
            SIG_INIT: return INIT_GAP_MAX_NS;
            default: return SAS_GAP_MAX_NS;
        endcase
    endfunction

endpackage

// file: src/oobseq_top.sv
// Out-of-band signal generator, detector and port selection sequencer
`timescale 1ns/10ps
module oobseq_top
    import oobseq_pkg::*;
#(
    parameter int unsigned PS_SHORT_CYC = PORT_SELECT_SHORT_GAP_CYC,
    parameter int unsigned PS_LONG_CYC = PORT_SELECT_LONG_GAP_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic opticalMode,
    input wire logic sendReq,
    input wire oobseqSig_t sendSig,
    input wire logic portSelReq,
    input wire logic dwordSyncLost,
    input wire logic rxEnergyPin,
    output oobseqTxLine_t txLine,
    output logic txBusy,
    output oobseqRxEvt_t rxEvt
);

    // ================================================================
    // State
    typedef struct packed {
        oobseqTxState_t txState;
        logic [16:0] txCnt;
        logic [2:0] pairCnt;
        oobseqSig_t txSig;
        logic [2:0] psLeft;
        logic [2:0] psIdx;
        logic [16:0] psTimer;
        logic energyMeta;
        logic energySync;
        logic energyPrev;
        logic [4:0] idleCnt;
        oobseqSig_t rxCand;
        logic [1:0] rxMatch;
        logic sasWait;
        logic [7:0] sasTimer;
        oobseqTxLine_t txLine;
        logic txBusy;
        oobseqRxEvt_t rxEvt;
    } oobseqState_t;

    oobseqState_t st_r;
    oobseqState_t st_nxt;

    // Idle and negation length for a signal
    function automatic logic [16:0] idleLen(oobseqSig_t s, logic neg);
        case (s)
            SIG_WAKE: idleLen = 17'(neg ? WAKE_NEG_CYC : WAKE_IDLE_CYC);
            SIG_INIT: idleLen = 17'(neg ? INIT_NEG_CYC : INIT_IDLE_CYC);
            default: idleLen = 17'(neg ? SAS_NEG_CYC : SAS_IDLE_CYC);
        endcase
    endfunction

    // Zero-dword count of an optical idle
    function automatic logic [9:0] zeroDw(oobseqSig_t s);
        case (s)
            SIG_WAKE: zeroDw = WAKE_ZERO_DWORDS;
            SIG_INIT: zeroDw = INIT_ZERO_DWORDS;
            default: zeroDw = SAS_ZERO_DWORDS;
        endcase
    endfunction

    // Line settings for idle or burst in the selected mode
    function automatic oobseqTxLine_t lineFor(logic burst, oobseqSig_t s, logic opt);
        lineFor = '0;
        if (burst) begin
            lineFor.burstAlign3 = opt;
            lineFor.burstDc = !opt;
        end else if (opt) begin
            lineFor.opticalIdle = 1'b1;
            lineFor.idlePrims = OPT_IDLE_PRIMS;
            lineFor.zeroDwords = zeroDw(s);
        end else begin
            lineFor.elecIdle = 1'b1;
        end
    endfunction

    // Next-state logic
    always_comb begin
        oobseqSig_t gapSig;
        logic start;
        oobseqSig_t startSig;
        gapSig = SIG_NONE;
        start = 1'b0;
        startSig = SIG_INIT;
        st_nxt = st_r;
        st_nxt.rxEvt = '0;

        // Pin synchroniser for the squelch output
        st_nxt.energyMeta = rxEnergyPin;
        st_nxt.energySync = st_r.energyMeta;
        st_nxt.energyPrev = st_r.energySync;

        // Port selection pacing from the first burst start of each signal
        if (st_r.psTimer != 17'h0) begin
            st_nxt.psTimer = st_r.psTimer - 17'h1;
        end
        if (st_r.txState == TX_READY) begin
            if (st_r.psLeft != 3'h0 && st_r.psTimer == 17'h0) begin
                start = 1'b1;
                st_nxt.psLeft = st_r.psLeft - 3'h1;
            end else if (portSelReq && st_r.psLeft == 3'h0) begin
                start = 1'b1;
                st_nxt.psLeft = PORT_SELECT_SIGNALS - 3'h1;
                st_nxt.psIdx = 3'h0;
            end else if (sendReq && sendSig != SIG_NONE && st_r.psLeft == 3'h0) begin
                start = 1'b1;
                startSig = sendSig;
            end
        end

        // Transmit sequencer
        case (st_r.txState)
            TX_READY: begin
                st_nxt.txLine = lineFor(1'b0, st_r.txSig, opticalMode);
                if (start) begin
                    st_nxt.txState = TX_IDLE;
                    st_nxt.txSig = startSig;
                    st_nxt.pairCnt = 3'h0;
                    st_nxt.txCnt = idleLen(startSig, 1'b0) - 17'h1;
                    st_nxt.txLine = lineFor(1'b0, startSig, opticalMode);
                end
            end
            TX_IDLE: begin
                if (st_r.txCnt == 17'h0) begin
                    st_nxt.txState = TX_BURST;
                    st_nxt.txCnt = 17'(BURST_CYC) - 17'h1;
                    st_nxt.txLine = lineFor(1'b1, st_r.txSig, opticalMode);
                    if (st_r.pairCnt == 3'h0 && st_r.psLeft != 3'h0) begin
                        // Short and long gaps alternate
                        st_nxt.psTimer = st_r.psIdx[0] ? 17'(PS_LONG_CYC) - 17'h1
                                                       : 17'(PS_SHORT_CYC) - 17'h1;
                        st_nxt.psIdx = st_r.psIdx + 3'h1;
                    end
                end else begin
                    st_nxt.txCnt = st_r.txCnt - 17'h1;
                end
            end
            TX_BURST: begin
                if (st_r.txCnt == 17'h0) begin
                    st_nxt.pairCnt = st_r.pairCnt + 3'h1;
                    st_nxt.txLine = lineFor(1'b0, st_r.txSig, opticalMode);
                    if (st_r.pairCnt + 3'h1 == PAIRS_PER_SIGNAL) begin
                        st_nxt.txState = TX_NEGATE;
                        st_nxt.txCnt = idleLen(st_r.txSig, 1'b1) - 17'h1;
                    end else begin
                        st_nxt.txState = TX_IDLE;
                        st_nxt.txCnt = idleLen(st_r.txSig, 1'b0) - 17'h1;
                    end
                end else begin
                    st_nxt.txCnt = st_r.txCnt - 17'h1;
                end
            end
            TX_NEGATE: begin
                if (st_r.txCnt == 17'h0) begin
                    st_nxt.txState = TX_READY;
                    if (st_r.txSig == SIG_SAS) begin
                        st_nxt.sasWait = 1'b1;
                        st_nxt.sasTimer = 8'(SAS_TIMEOUT_CYC);
                    end
                end else begin
                    st_nxt.txCnt = st_r.txCnt - 17'h1;
                end
            end
            default: begin
                st_nxt.txState = TX_READY;
            end
        endcase
        st_nxt.txBusy = (st_nxt.txState != TX_READY) || (st_nxt.psLeft != 3'h0);

        // Receive: energy alone marks a burst, any length accepted
        if (st_r.energySync) begin
            st_nxt.idleCnt = 5'h0;
            if (!st_r.energyPrev && st_r.idleCnt != IDLE_CNT_MAX) begin
                gapSig = oobseqGapClass(st_r.idleCnt);
                if (gapSig != SIG_NONE && gapSig == st_r.rxCand) begin
                    if (st_r.rxMatch != GAPS_TO_MATCH) begin
                        st_nxt.rxMatch = st_r.rxMatch + 2'h1;
                    end
                end else begin
                    st_nxt.rxCand = gapSig;
                    st_nxt.rxMatch = (gapSig == SIG_NONE) ? 2'h0 : 2'h1;
                end
            end
        end else if (st_r.idleCnt != IDLE_CNT_MAX) begin
            st_nxt.idleCnt = st_r.idleCnt + 5'h1;
        end

        // End of signal once the gap passes the negation length
        if (!st_r.energySync && st_r.rxCand != SIG_NONE
                && int'(st_r.idleCnt) * CLK_PERIOD_NS > oobseqNegNs(st_r.rxCand)) begin
            if (st_r.rxMatch == GAPS_TO_MATCH && dwordSyncLost) begin
                st_nxt.rxEvt.wake = (st_r.rxCand == SIG_WAKE);
                st_nxt.rxEvt.init = (st_r.rxCand == SIG_INIT);
                st_nxt.rxEvt.sas = (st_r.rxCand == SIG_SAS);
            end
            st_nxt.rxCand = SIG_NONE;
            st_nxt.rxMatch = 2'h0;
        end

        // Answering COMSAS watch
        if (st_r.sasWait && st_nxt.rxEvt.sas) begin
            st_nxt.sasWait = 1'b0;
        end else if (st_r.sasWait) begin
            if (st_r.sasTimer == 8'h0) begin
                st_nxt.sasWait = 1'b0;
                st_nxt.rxEvt.sasTimeout = 1'b1;
            end else begin
                st_nxt.sasTimer = st_r.sasTimer - 8'h1;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.txState <= TX_READY;
            st_r.txSig <= SIG_INIT;
            st_r.rxCand <= SIG_NONE;
            st_r.idleCnt <= IDLE_CNT_MAX;
            st_r.txLine.elecIdle <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the state register
    assign txLine = st_r.txLine;
    assign txBusy = st_r.txBusy;
    assign rxEvt = st_r.rxEvt;

endmodule

// file: test/oobseq_props.sv
// Port checker for the out-of-band sequencer
`timescale 1ns/10ps
module oobseq_props
    import oobseq_pkg::*;
#(
    parameter int unsigned PS_SHORT_CYC = PORT_SELECT_SHORT_GAP_CYC,
    parameter int unsigned PS_LONG_CYC = PORT_SELECT_LONG_GAP_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic opticalMode,
    input wire logic sendReq,
    input wire oobseqSig_t sendSig,
    input wire logic portSelReq,
    input wire logic dwordSyncLost,
    input wire logic rxEnergyPin,
    input wire oobseqTxLine_t txLine,
    input wire logic txBusy,
    input wire oobseqRxEvt_t rxEvt
);
    // ====================
    // Helpers
    logic [4:0] lowCnt_r;
    logic [3:0] openIdle_r;
    logic seenBurst_r;
    logic [7:0] sasCnt_r;
    wire burstOn = txLine.burstDc | txLine.burstAlign3;
    wire anyEvt = rxEvt.wake | rxEvt.init | rxEvt.sas;

    // Quiet pin length, opening idle of a sequence, cycles since a COMSAS ended
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lowCnt_r <= 5'h00;
            openIdle_r <= 4'h0;
            seenBurst_r <= 1'b0;
            sasCnt_r <= 8'hff;
        end else begin
            lowCnt_r <= rxEnergyPin ? 5'h00 : lowCnt_r + {4'h0, lowCnt_r != 5'h1f};
            if (!txBusy) begin
                openIdle_r <= 4'h0;
                seenBurst_r <= 1'b0;
            end else if (burstOn) begin
                seenBurst_r <= 1'b1;
            end else if (!seenBurst_r && openIdle_r != 4'hf) begin
                openIdle_r <= openIdle_r + 4'h1;
            end
            // Only a COMSAS opens with ten idle cycles or more; later signals keep the count
            if (!txBusy && openIdle_r >= 4'ha) begin
                sasCnt_r <= 8'h01;
            end else begin
                sasCnt_r <= sasCnt_r + {7'h00, sasCnt_r != 8'hff};
            end
        end
    end

    // ====================
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence burstHold;
        burstOn [*2] ##1 !burstOn;
    endsequence

    a_burst_len: assert property ($rose(burstOn) |-> burstHold)
        else $error("burst length wrong");
    a_burst_busy: assert property (burstOn |-> txBusy)
        else $error("burst outside a sequence");
    a_start_idle: assert property ($rose(txBusy) |-> !burstOn && (txLine.elecIdle || txLine.opticalIdle))
        else $error("sequence does not open with idle");
    a_mode_excl: assert property (!(txLine.elecIdle && txLine.opticalIdle) && !(txLine.burstDc && txLine.burstAlign3))
        else $error("both modes on the line");
    a_dc_line: assert property (txBusy && !opticalMode && !$past(opticalMode) |-> !txLine.opticalIdle && !txLine.burstAlign3)
        else $error("optical fill in dc mode");
    a_opt_line: assert property (txBusy && opticalMode && $past(opticalMode) |-> !txLine.elecIdle && !txLine.burstDc)
        else $error("dc fill in optical mode");
    a_opt_fill: assert property (txLine.opticalIdle |-> txLine.idlePrims == 3'h6 && txLine.zeroDwords inside {10'h002, 10'h012, 10'h042})
        else $error("optical idle make-up wrong");
    a_evt_sync: assert property (anyEvt |-> $past(dwordSyncLost))
        else $error("detection while in sync");
    a_evt_pulse: assert property (anyEvt |=> !anyEvt && $onehot0({rxEvt.wake, rxEvt.init, rxEvt.sas}))
        else $error("event not a single pulse");
    a_neg_gap: assert property ((rxEvt.wake -> lowCnt_r >= 5'h02) && (rxEvt.init -> lowCnt_r >= 5'h06) && (rxEvt.sas -> lowCnt_r >= 5'h10))
        else $error("event before negation gap");
    a_sas_wait: assert property (rxEvt.sasTimeout |-> sasCnt_r >= 8'h88)
        else $error("timeout too early");
endmodule

bind oobseq_top oobseq_props #(.PS_SHORT_CYC(PS_SHORT_CYC), .PS_LONG_CYC(PS_LONG_CYC)) u_props (
    .clk_sys(clk_sys), .rst_b(rst_b), .opticalMode(opticalMode), .sendReq(sendReq),
    .sendSig(sendSig), .portSelReq(portSelReq), .dwordSyncLost(dwordSyncLost),
    .rxEnergyPin(rxEnergyPin), .txLine(txLine), .txBusy(txBusy), .rxEvt(rxEvt));

// file: test/oobseq_partner.sv
// Attached phy model sending out-of-band bursts towards the receiver
`timescale 1ns/10ps
module oobseq_partner (
    input wire logic clk_sys,
    input wire logic go,
    input wire logic [4:0] gapCyc,
    input wire logic [2:0] burstCyc,
    output logic rxEnergy,
    output logic busy
);
    // ====================
    // Six quiet gaps each closed by a burst, then quiet for negation
    initial begin
        rxEnergy = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (go && !busy) begin
                busy <= 1'b1;
                repeat (6) begin
                    repeat (gapCyc) @(posedge clk_sys);
                    rxEnergy <= 1'b1;
                    repeat (burstCyc) @(posedge clk_sys);
                    rxEnergy <= 1'b0;
                end
                busy <= 1'b0;
            end
        end
    end
endmodule

// file: test/oobseq_tb.sv
// Self-checking bench for the out-of-band sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module oobseq_tb
    import oobseq_pkg::*;
;
    // ====================
    // Stimulus and tables
    localparam int PS_S = 40;
    localparam int PS_L = 80;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic opticalMode = 1'b0;
    logic sendReq = 1'b0;
    oobseqSig_t sendSig = SIG_NONE;
    logic portSelReq = 1'b0;
    logic dwordSyncLost = 1'b1;
    logic rxEnergyPin;
    logic go = 1'b0;
    logic [4:0] gapCyc = 5'h01;
    logic [2:0] burstCyc = 3'h2;
    logic pBusy;
    oobseqTxLine_t txLine;
    logic txBusy;
    oobseqRxEvt_t rxEvt;
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'h00008def;
    int idlU[4] = '{0, 160, 480, 1440};
    int negU[4] = '{0, 280, 800, 2400};
    int zdw[4] = '{0, 2, 18, 66};
    int gaps[8] = '{1, 2, 3, 5, 6, 10, 15, 16};
    int psGap[4] = '{PS_S, PS_L, PS_S, PS_L};

    // Clock of 100 ns
    always #50 clk_sys = ~clk_sys;

    oobseq_top #(.PS_SHORT_CYC(PS_S), .PS_LONG_CYC(PS_L)) u_oobseq_top (
        .clk_sys(clk_sys), .rst_b(rst_b), .opticalMode(opticalMode), .sendReq(sendReq),
        .sendSig(sendSig), .portSelReq(portSelReq), .dwordSyncLost(dwordSyncLost),
        .rxEnergyPin(rxEnergyPin), .txLine(txLine), .txBusy(txBusy), .rxEvt(rxEvt));
    oobseq_partner u_oobseq_partner (.clk_sys(clk_sys), .go(go), .gapCyc(gapCyc),
        .burstCyc(burstCyc), .rxEnergy(rxEnergyPin), .busy(pBusy));

    // ====================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Units of 666.6 ps to whole cycles, rounded up
    function automatic int u2c(input int u);
        return (u * 6666 + 999999) / 1000000;
    endfunction

    task automatic final_report();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic hang();
        mismatches++;
        final_report();
    endtask

    // Send one signal, try to disturb it, and measure its run lengths
    task automatic txRun(input oobseqSig_t s, input logic opt);
        int exp[$];
        int runs[$];
        int cnt, k;
        logic b, pb;
        for (k = 0; k < 6; k++) begin
            exp.push_back(u2c(idlU[s]));
            exp.push_back(u2c(160));
        end
        exp.push_back(u2c(negU[s]));
        @(posedge clk_sys);
        opticalMode <= opt;
        @(posedge clk_sys);
        sendSig <= s;
        sendReq <= 1'b1;
        cnt = 0;
        pb = 1'b0;
        for (k = 0; k < 600; k++) begin
            @(posedge clk_sys);
            sendSig <= (s == SIG_WAKE) ? SIG_SAS : SIG_WAKE;
            if (k == 1) sendReq <= 1'b0;
            @(negedge clk_sys);
            b = opt ? txLine.burstAlign3 : txLine.burstDc;
            if (k == 0) begin
                `CHK({txLine.elecIdle, txLine.opticalIdle}, {~opt, opt})
                if (opt) `CHK({txLine.idlePrims, txLine.zeroDwords}, {3'h6, 10'(zdw[s])})
            end
            if (!txBusy) break;
            if (b == pb) cnt++;
            else begin
                runs.push_back(cnt);
                cnt = 1;
                pb = b;
            end
        end
        if (k == 600) hang();
        runs.push_back(cnt);
        `CHK(runs.size(), exp.size())
        for (k = 0; k < exp.size() && k < runs.size(); k++) `CHK(runs[k], exp[k])
    endtask

    // Partner sends one signal; gather the event pulses that follow
    task automatic rxRun(input int gap, input logic sync, input int wt);
        logic [3:0] acc;
        logic [3:0] e;
        int k;
        acc = 4'h0;
        e = 4'h0;
        if (gap * 100 >= 35 && gap * 100 < 175) e = 4'h8;
        else if (gap * 100 >= 175 && gap * 100 < 525) e = 4'h4;
        else if (gap * 100 >= 525 && gap * 100 < 1575) e = 4'h2;
        @(posedge clk_sys);
        seed = xs(seed);
        burstCyc <= 3'h1 + 3'(seed % 3);
        gapCyc <= 5'(gap);
        dwordSyncLost <= sync;
        go <= 1'b1;
        for (k = 0; k < 400 && (k == 0 || go || pBusy); k++) begin
            @(posedge clk_sys);
            if (pBusy) go <= 1'b0;
            @(negedge clk_sys);
            acc = acc | rxEvt;
        end
        if (k == 400) hang();
        repeat (wt) begin
            @(negedge clk_sys);
            acc = acc | rxEvt;
        end
        `CHK(acc, sync ? {e[3:1], 1'b0} : 4'h0)
    endtask

    // ====================
    // Main sequence
    initial begin
        int k, n, tmo, span;
        int rises[$];
        int starts[$];
        logic pb;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK({txLine, txBusy, rxEvt}, {17'h10000, 1'b0, 4'h0})
        @(posedge clk_sys);
        rst_b <= 1'b1;
        for (k = 0; k < 8; k++) rxRun(gaps[k], 1'b1, 30);
        rxRun(1, 1'b0, 30);
        rxRun(10, 1'b0, 30);
        for (k = 0; k < 6; k++) txRun(oobseqSig_t'(k % 3 + 1), logic'(k / 3));
        @(posedge clk_sys);
        opticalMode <= 1'b0;
        portSelReq <= 1'b1;
        @(posedge clk_sys);
        portSelReq <= 1'b0;
        pb = 1'b0;
        for (k = 0; k < 1000 && (k < 3 || txBusy); k++) begin
            @(negedge clk_sys);
            if (txLine.burstDc && !pb) rises.push_back(k);
            pb = txLine.burstDc;
        end
        if (k == 1000) hang();
        // A new signal begins once a whole signal's pairs have gone by
        span = 6 * (u2c(480) + u2c(160));
        for (n = 0; n < rises.size(); n++) begin
            if (n == 0 || rises[n] - starts[starts.size() - 1] >= span) starts.push_back(rises[n]);
        end
        `CHK(starts.size(), 5)
        // Gap runs to the next signal's start; its first burst follows one idle
        for (n = 1; n < 5 && n < starts.size(); n++) begin
            `CHK(starts[n] - starts[n - 1], psGap[n - 1] + u2c(idlU[SIG_INIT]))
        end
        txRun(SIG_SAS, 1'b0);
        tmo = (13686 + 99) / 100;
        for (n = 0; n < 300 && rxEvt.sasTimeout !== 1'b1; n++) @(negedge clk_sys);
        if (n == 300) hang();
        `CHK(n >= tmo - 2 && n <= tmo + 3, 1'b1)
        txRun(SIG_SAS, 1'b1);
        rxRun(10, 1'b1, 150);
        final_report();
    end
endmodule
